// ---- rtl/epd_update_control_cmds.sv ----
// command decoder for restart, temperature source and value, update options and activation
// assumes host bytes arrive from a serial front end clocked by sys_clk_i, one per valid cycle
//
// Overview of operation
// [R1] restart restores defaults except deep sleep
// [R2] busy high until restart completes
// [R3] restart leaves image memories untouched
// [R4] 0x18 byte selects temperature source
// [R5] 0x1a two bytes form 12-bit temperature
// [R6] 0x20 runs only enabled update stages
// [R7] host waits for busy low before commands
// [R8] first byte high nibble sets colour memory use
// [R9] first byte low nibble sets black/white use
// [R10] second byte bit 7 picks source range
// [R11] 0x22 byte selects stages, default 0xff
// [R12] stage byte decodes into clock/analog steps
// [R13] parameter bytes belong to latest command
`timescale 1ns/1ps

module epd_update_control_cmds (
    input  wire logic                 sys_clk_i,
    input  wire logic                 rst_b_i,
    input  wire epd_pkg::host_byte_t  host_byte_i,
    output logic                      busy_o,
    output logic [7:0]                temp_source_o,
    output logic [11:0]               temp_value_o,
    output epd_pkg::update_opt_t      update_opt_o,
    output logic [7:0]                update_stage_o,
    output logic [7:0]                source_first_o,
    output logic [7:0]                source_last_o,
    output logic [1:0]                deep_sleep_o,
    output logic                      int_clk_en_o,
    output logic                      analog_en_o,
    output logic                      display_drive_o
);

    ////////////////////////////////////////////////////////////////////////////////
    // declarations
    epd_pkg::seq_state_t   state_q;
    epd_pkg::seq_state_t   state_d;
    epd_pkg::update_opt_t  opt_q;
    epd_pkg::stage_en_t    stage_en;
    logic [7:0]            cmd_q;
    logic [1:0]            param_idx_q;
    logic [7:0]            temp_src_q;
    logic [11:0]           temp_val_q;
    logic [7:0]            stage_sel_q;
    logic [1:0]            deep_sleep_q;
    logic                  busy_q;
    logic                  clk_en_q;
    logic                  ana_en_q;
    logic                  display_q;
    logic [7:0]            src_first_q;
    logic [7:0]            src_last_q;
    logic                  take;
    logic                  cmd_take;
    logic                  par_take;
    logic                  par0;
    logic                  par1;
    logic                  restart_go;
    logic                  act_go;
    logic                  wr_temp_src;
    logic                  wr_temp_hi;
    logic                  wr_temp_lo;
    logic                  wr_opt_a;
    logic                  wr_opt_b;
    logic                  wr_stage;
    logic                  wr_sleep;
    logic                  restart_done;
    logic                  stage_done;
    logic                  stage_on;
    logic                  stage_run;

    ////////////////////////////////////////////////////////////////////////////////
    // byte intake; bytes that arrive while busy are dropped
    assign take       = host_byte_i.valid && !busy_q;
    assign cmd_take   = take && !host_byte_i.is_param;
    assign par_take   = take && host_byte_i.is_param;
    assign par0       = par_take && (param_idx_q == 2'h0);                  // [R13]
    assign par1       = par_take && (param_idx_q == 2'h1);                  // [R13]
    assign restart_go = cmd_take && (host_byte_i.data == epd_pkg::CMD_RESTART);
    assign act_go     = cmd_take && (host_byte_i.data == epd_pkg::CMD_ACTIVATE);

    // parameter write strobes, steered by the latest command code
    assign wr_temp_src = par0 && (cmd_q == epd_pkg::CMD_TEMP_SRC);          // [R4]
    assign wr_temp_hi  = par0 && (cmd_q == epd_pkg::CMD_TEMP_WR);           // [R5]
    assign wr_temp_lo  = par1 && (cmd_q == epd_pkg::CMD_TEMP_WR);           // [R5]
    assign wr_opt_a    = par0 && (cmd_q == epd_pkg::CMD_RAM_OPT);           // [R8] [R9]
    assign wr_opt_b    = par1 && (cmd_q == epd_pkg::CMD_RAM_OPT);           // [R10]
    assign wr_stage    = par0 && (cmd_q == epd_pkg::CMD_STAGE_SEL);         // [R11]
    assign wr_sleep    = par0 && (cmd_q == epd_pkg::CMD_DEEP_SLEEP);

    ////////////////////////////////////////////////////////////////////////////////
    // command code and parameter position
    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            cmd_q       <= 8'h00;
            param_idx_q <= 2'h0;
        end else if (cmd_take) begin
            cmd_q       <= host_byte_i.data;                                // [R13]
            param_idx_q <= 2'h0;
        end else if (par_take && param_idx_q != 2'h3) begin
            param_idx_q <= param_idx_q + 2'h1;                              // [R13]
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // settings; restart reloads all but the deep sleep choice, no memory strobe here
    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            temp_src_q  <= epd_pkg::TEMP_SRC_RST;
            temp_val_q  <= epd_pkg::TEMP_VAL_RST;
            opt_q       <= '0;
            stage_sel_q <= epd_pkg::STAGE_SEL_RST;
        end else if (restart_go) begin
            temp_src_q  <= epd_pkg::TEMP_SRC_RST;                           // [R1] [R3]
            temp_val_q  <= epd_pkg::TEMP_VAL_RST;                           // [R1]
            opt_q       <= '0;                                              // [R1]
            stage_sel_q <= epd_pkg::STAGE_SEL_RST;                          // [R1]
        end else begin
            if (wr_temp_src) begin
                temp_src_q <= host_byte_i.data;                             // [R4]
            end
            if (wr_temp_hi) begin
                temp_val_q[11:4] <= host_byte_i.data;                       // [R5]
            end
            if (wr_temp_lo) begin
                temp_val_q[3:0] <= host_byte_i.data[7:epd_pkg::TEMP_LO_LSB]; // [R5]
            end
            if (wr_opt_a) begin
                opt_q.color_opt <= host_byte_i.data[epd_pkg::COLOR_OPT_LSB +: 4]; // [R8]
                opt_q.bw_opt    <= host_byte_i.data[epd_pkg::BW_OPT_LSB +: 4];    // [R9]
            end
            if (wr_opt_b) begin
                opt_q.range_narrow <= host_byte_i.data[epd_pkg::RANGE_BIT]; // [R10]
            end
            if (wr_stage) begin
                stage_sel_q <= host_byte_i.data;                            // [R11]
            end
        end
    end

    // deep sleep choice survives a restart
    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            deep_sleep_q <= epd_pkg::DEEP_SLEEP_RST;
        end else if (wr_sleep) begin
            deep_sleep_q <= host_byte_i.data[1:0];                          // [R1]
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // stage decode and timers
    stage_decode u_stage_decode (
        .sel_i (stage_sel_q),
        .en_o  (stage_en)
    );

    hold_timer #(.COUNT(epd_pkg::RESTART_CYCLES)) u_restart_timer (
        .sys_clk_i (sys_clk_i),
        .rst_b_i   (rst_b_i),
        .run_i     (state_q == epd_pkg::ST_RESTART),
        .done_o    (restart_done)
    );

    hold_timer #(.COUNT(epd_pkg::STAGE_CYCLES)) u_stage_timer (
        .sys_clk_i (sys_clk_i),
        .rst_b_i   (rst_b_i),
        .run_i     (stage_run),
        .done_o    (stage_done)
    );

    // enable of the current stage; disabled stages pass in one cycle
    always_comb begin
        unique case (state_q)
            epd_pkg::ST_CLK_ON:  stage_on = stage_en.clk_on;                // [R12]
            epd_pkg::ST_ANA_ON:  stage_on = stage_en.ana_on;                // [R12]
            epd_pkg::ST_DISPLAY: stage_on = stage_en.display;               // [R6]
            epd_pkg::ST_ANA_OFF: stage_on = stage_en.ana_off;
            epd_pkg::ST_CLK_OFF: stage_on = stage_en.clk_off;               // [R12]
            default:             stage_on = 1'b0;
        endcase
    end
    assign stage_run = stage_on;

    ////////////////////////////////////////////////////////////////////////////////
    // sequence state machine
    always_comb begin
        state_d = state_q;
        unique case (state_q)
            epd_pkg::ST_IDLE: begin
                if (restart_go) begin
                    state_d = epd_pkg::ST_RESTART;                          // [R2]
                end else if (act_go) begin
                    state_d = epd_pkg::ST_CLK_ON;                           // [R6]
                end
            end
            epd_pkg::ST_RESTART: begin
                if (restart_done) begin
                    state_d = epd_pkg::ST_IDLE;                             // [R2]
                end
            end
            epd_pkg::ST_CLK_ON: begin
                if (!stage_on || stage_done) begin
                    state_d = epd_pkg::ST_ANA_ON;
                end
            end
            epd_pkg::ST_ANA_ON: begin
                if (!stage_on || stage_done) begin
                    state_d = epd_pkg::ST_DISPLAY;
                end
            end
            epd_pkg::ST_DISPLAY: begin
                if (!stage_on || stage_done) begin
                    state_d = epd_pkg::ST_ANA_OFF;
                end
            end
            epd_pkg::ST_ANA_OFF: begin
                if (!stage_on || stage_done) begin
                    state_d = epd_pkg::ST_CLK_OFF;
                end
            end
            epd_pkg::ST_CLK_OFF: begin
                if (!stage_on || stage_done) begin
                    state_d = epd_pkg::ST_IDLE;
                end
            end
            default: state_d = epd_pkg::ST_IDLE;
        endcase
    end

    // state, busy and stage effects
    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            state_q   <= epd_pkg::ST_IDLE;
            busy_q    <= 1'b0;
            clk_en_q  <= 1'b0;
            ana_en_q  <= 1'b0;
            display_q <= 1'b0;
        end else begin
            state_q   <= state_d;
            busy_q    <= (state_d != epd_pkg::ST_IDLE);                     // [R2] [R6]
            display_q <= (state_d == epd_pkg::ST_DISPLAY) && stage_en.display;
            if (restart_go) begin
                clk_en_q <= 1'b0;                                           // [R1]
                ana_en_q <= 1'b0;                                           // [R1]
            end else if (stage_done) begin
                unique case (state_q)
                    epd_pkg::ST_CLK_ON:  clk_en_q <= 1'b1;                  // [R12]
                    epd_pkg::ST_ANA_ON:  ana_en_q <= 1'b1;                  // [R12]
                    epd_pkg::ST_ANA_OFF: ana_en_q <= 1'b0;
                    epd_pkg::ST_CLK_OFF: clk_en_q <= 1'b0;                  // [R12]
                    default: ;
                endcase
            end
        end
    end

    // active source window from the range choice
    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            src_first_q <= epd_pkg::SRC_FULL_FIRST;
            src_last_q  <= epd_pkg::SRC_FULL_LAST;
        end else begin
            src_first_q <= opt_q.range_narrow ? epd_pkg::SRC_NARROW_FIRST
                                              : epd_pkg::SRC_FULL_FIRST;   // [R10]
            src_last_q  <= opt_q.range_narrow ? epd_pkg::SRC_NARROW_LAST
                                              : epd_pkg::SRC_FULL_LAST;    // [R10]
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // outputs, all straight from flip-flops
    assign busy_o          = busy_q;
    assign temp_source_o   = temp_src_q;
    assign temp_value_o    = temp_val_q;
    assign update_opt_o    = opt_q;
    assign update_stage_o  = stage_sel_q;
    assign source_first_o  = src_first_q;
    assign source_last_o   = src_last_q;
    assign deep_sleep_o    = deep_sleep_q;
    assign int_clk_en_o    = clk_en_q;
    assign analog_en_o     = ana_en_q;
    assign display_drive_o = display_q;

    ////////////////////////////////////////////////////////////////////////////////
    // checks
    a_restart_defaults: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i) // [R1]
        restart_go |=> temp_src_q == epd_pkg::TEMP_SRC_RST && temp_val_q == epd_pkg::TEMP_VAL_RST
            && stage_sel_q == epd_pkg::STAGE_SEL_RST && opt_q == '0 && $stable(deep_sleep_q))
        else $error("restart did not restore defaults");

    a_restart_busy: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i) // [R2]
        restart_go |=> busy_q [*8] ##[1:40] !busy_q)
        else $error("busy wrong around restart");

    a_temp_source: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i) // [R4]
        wr_temp_src |=> temp_src_q == $past(host_byte_i.data))
        else $error("temperature source not taken");

    a_temp_low_nibble: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i) // [R5]
        par_take && cmd_q == epd_pkg::CMD_TEMP_WR && param_idx_q == 2'h1
        |=> temp_val_q[3:0] == $past(host_byte_i.data[7:4]))
        else $error("temperature low bits wrong");

    a_activate_busy: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i) // [R6]
        act_go |=> busy_q && state_q == epd_pkg::ST_CLK_ON)
        else $error("activation did not start sequence");

    a_ram_option: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i) // [R8]
        wr_opt_a |=> {opt_q.color_opt, opt_q.bw_opt} == $past(host_byte_i.data))
        else $error("ram option not stored");

    a_source_range: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i) // [R10]
        wr_opt_b ##1 !wr_opt_b |=> src_last_q == ($past(host_byte_i.data[7], 2)
            ? epd_pkg::SRC_NARROW_LAST : epd_pkg::SRC_FULL_LAST))
        else $error("source range not applied");

    a_clock_stage: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i) // [R12]
        state_q == epd_pkg::ST_CLK_ON && stage_done |=> clk_en_q)
        else $error("clock stage did not enable clock");

    a_param_order: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i) // [R13]
        cmd_take |=> param_idx_q == 2'h0 && cmd_q == $past(host_byte_i.data))
        else $error("command did not restart parameter count");

endmodule

// ---- rtl/epd_pkg.sv ----
// shared constants, enumerations and carriers for the e-paper update command decoder
// assumes one 40 MHz clock and a byte stream already framed by the serial front end
package epd_pkg;

    ////////////////////////////////////////////////////////////////////////////////
    // command codes
    localparam logic [7:0] CMD_DEEP_SLEEP = 8'h10;
    localparam logic [7:0] CMD_RESTART    = 8'h12;
    localparam logic [7:0] CMD_TEMP_SRC   = 8'h18;
    localparam logic [7:0] CMD_TEMP_WR    = 8'h1a;
    localparam logic [7:0] CMD_ACTIVATE   = 8'h20;
    localparam logic [7:0] CMD_RAM_OPT    = 8'h21;
    localparam logic [7:0] CMD_STAGE_SEL  = 8'h22;

    ////////////////////////////////////////////////////////////////////////////////
    // reset and selection values
    localparam logic [7:0]  TEMP_SRC_EXTERNAL = 8'h48;
    localparam logic [7:0]  TEMP_SRC_INTERNAL = 8'h80;
    localparam logic [7:0]  TEMP_SRC_RST      = TEMP_SRC_EXTERNAL;
    localparam logic [11:0] TEMP_VAL_RST      = 12'h7ff;
    localparam logic [7:0]  STAGE_SEL_RST     = 8'hff;
    localparam logic [1:0]  DEEP_SLEEP_RST    = 2'h0;
    localparam logic [3:0]  RAM_OPT_NORMAL    = 4'h0;
    localparam logic [3:0]  RAM_OPT_ZERO      = 4'h4;
    localparam logic [3:0]  RAM_OPT_INVERT    = 4'h8;

    ////////////////////////////////////////////////////////////////////////////////
    // field positions inside parameter bytes
    localparam int COLOR_OPT_LSB = 4;
    localparam int BW_OPT_LSB    = 0;
    localparam int RANGE_BIT     = 7;
    localparam int TEMP_LO_LSB   = 4;
    localparam int STG_CLK_ON    = 7;
    localparam int STG_ANA_ON    = 6;
    localparam int STG_DISPLAY   = 2;
    localparam int STG_ANA_OFF   = 1;
    localparam int STG_CLK_OFF   = 0;

    ////////////////////////////////////////////////////////////////////////////////
    // source output window limits
    localparam logic [7:0] SRC_FULL_FIRST   = 8'h00;
    localparam logic [7:0] SRC_FULL_LAST    = 8'haf;
    localparam logic [7:0] SRC_NARROW_FIRST = 8'h08;
    localparam logic [7:0] SRC_NARROW_LAST  = 8'ha7;

    ////////////////////////////////////////////////////////////////////////////////
    // timing, least times rounded up to whole cycles
    localparam int CLK_MHZ         = 40;
    localparam int RESTART_TIME_NS = 1000;
    localparam int STAGE_TIME_NS   = 500;
    localparam int RESTART_CYCLES  = (RESTART_TIME_NS * CLK_MHZ + 999) / 1000;
    localparam int STAGE_CYCLES    = (STAGE_TIME_NS * CLK_MHZ + 999) / 1000;

    ////////////////////////////////////////////////////////////////////////////////
    // types
    typedef enum logic [2:0] {
        ST_IDLE    = 3'h0,
        ST_RESTART = 3'h1,
        ST_CLK_ON  = 3'h2,
        ST_ANA_ON  = 3'h3,
        ST_DISPLAY = 3'h4,
        ST_ANA_OFF = 3'h5,
        ST_CLK_OFF = 3'h6
    } seq_state_t;

    typedef struct packed {
        logic       valid;
        logic       is_param;
        logic [7:0] data;
    } host_byte_t;

    typedef struct packed {
        logic [3:0] color_opt;
        logic [3:0] bw_opt;
        logic       range_narrow;
    } update_opt_t;

    typedef struct packed {
        logic clk_on;
        logic ana_on;
        logic display;
        logic ana_off;
        logic clk_off;
    } stage_en_t;

endpackage

// ---- rtl/hold_timer.sv ----
// cycle counter that pulses done after COUNT cycles of run
// assumes run stays high until done; dropping run restarts the count
`timescale 1ns/1ps

module hold_timer #(
    parameter int COUNT = 4
) (
    input  wire logic sys_clk_i,
    input  wire logic rst_b_i,
    input  wire logic run_i,
    output wire logic done_o
);

    localparam int W = $clog2(COUNT + 1);
    localparam logic [W-1:0] LAST = W'(COUNT - 1);

    logic [W-1:0] count_q;
    logic [W-1:0] count_d;

    // done in the last counted cycle, then start over
    assign done_o  = run_i && (count_q == LAST);
    assign count_d = (!run_i || done_o) ? '0 : count_q + W'(1);

    // count register
    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            count_q <= '0;
        end else begin
            count_q <= count_d;
        end
    end

endmodule

// ---- rtl/stage_decode.sv ----
// splits the update stage selection byte into per stage enables
// assumes a stable selection byte from the owner register
`timescale 1ns/1ps

module stage_decode (
    input  wire logic [7:0]         sel_i,
    output epd_pkg::stage_en_t      en_o
);

    // one selection bit per sequence step
    assign en_o.clk_on  = sel_i[epd_pkg::STG_CLK_ON];
    assign en_o.ana_on  = sel_i[epd_pkg::STG_ANA_ON];
    assign en_o.display = sel_i[epd_pkg::STG_DISPLAY];
    assign en_o.ana_off = sel_i[epd_pkg::STG_ANA_OFF];
    assign en_o.clk_off = sel_i[epd_pkg::STG_CLK_OFF];

endmodule

// ---- sim/host_model.sv ----
// host side model that frames command and parameter bytes for the update command decoder
// assumes it shares sys_clk_i with the decoder and sees the decoder busy level
`timescale 1ns/1ps

module host_model (
    input  wire logic           sys_clk_i,
    input  wire logic           busy_i,
    output epd_pkg::host_byte_t host_byte_o
);
    int stalls = 0;

    initial host_byte_o = '0;

    ////////////////////////////////////////////////////////////////////////////////
    // one byte per call, launched just after a rising edge; a polite host waits for idle
    task automatic send(input logic is_param, input logic [7:0] data, input logic polite);
        int n;
        n = 0;
        while (polite && busy_i !== 1'b0 && n < 400) begin
            @(posedge sys_clk_i);
            n++;
        end
        if (polite && busy_i !== 1'b0) stalls++; // wait ran out, counted by the bench
        @(posedge sys_clk_i);
        host_byte_o <= '{valid: 1'b1, is_param: is_param, data: data};
    endtask

    // release: valid drops and the data lines show the inverse of the last byte
    task automatic release_bus();
        @(posedge sys_clk_i);
        host_byte_o <= '{valid: 1'b0, is_param: ~host_byte_o.is_param,
                         data: ~host_byte_o.data};
    endtask
endmodule

// ---- sim/epd_update_control_cmds_tb.sv ----
// self-checking bench for the update command decoder, table of settings writes then stage runs
// assumes the decoder contract: one byte per valid cycle, bytes dropped while busy
`timescale 1ns/1ps

module epd_update_control_cmds_tb;
    logic                 sys_clk_i;
    logic                 rst_b_i;
    epd_pkg::host_byte_t  host_byte;
    epd_pkg::update_opt_t update_opt;
    logic                 busy, int_clk_en, analog_en, display_drive;
    logic [7:0]           temp_source, update_stage, source_first, source_last;
    logic [11:0]          temp_value;
    logic [1:0]           deep_sleep;
    logic [2:0]           seen;
    int                   mismatches, cmp_count;
    wire logic [52:0]     state_w = {temp_source, temp_value, update_opt, update_stage,
                                     source_first, source_last};

    typedef struct { logic [7:0] cmd, a, b; int n; logic [52:0] exp; } row_t;
    typedef struct { logic [7:0] sel; logic [2:0] seen; logic [1:0] last; } stage_row_t;
    row_t rows [7] = '{
        '{8'h18, 8'h80, 8'h48, 2, {8'h80, 12'h7ff, 9'h000, 8'hff, 8'h00, 8'haf}},
        '{8'h1a, 8'h12, 8'h30, 2, {8'h80, 12'h123, 9'h000, 8'hff, 8'h00, 8'haf}},
        '{8'h21, 8'h48, 8'h80, 2, {8'h80, 12'h123, 9'h091, 8'hff, 8'h08, 8'ha7}},
        '{8'h21, 8'h84, 8'h7f, 2, {8'h80, 12'h123, 9'h108, 8'hff, 8'h00, 8'haf}},
        '{8'h3c, 8'h55, 8'h00, 1, {8'h80, 12'h123, 9'h108, 8'hff, 8'h00, 8'haf}},
        '{8'h22, 8'hc0, 8'h00, 1, {8'h80, 12'h123, 9'h108, 8'hc0, 8'h00, 8'haf}},
        '{8'h18, 8'h48, 8'h00, 1, {8'h48, 12'h123, 9'h108, 8'hc0, 8'h00, 8'haf}}};
    stage_row_t stages [4] = '{'{8'hff, 3'b111, 2'b00}, '{8'h80, 3'b100, 2'b10},
                               '{8'hc0, 3'b110, 2'b11}, '{8'h01, 3'b110, 2'b01}};

    ////////////////////////////////////////////////////////////////////////////////
    // clock, decoder and host model
    initial begin
        sys_clk_i = 1'b0;
        forever #12.5 sys_clk_i = ~sys_clk_i;
    end

    epd_update_control_cmds dut (
        .sys_clk_i       (sys_clk_i),
        .rst_b_i         (rst_b_i),
        .host_byte_i     (host_byte),
        .busy_o          (busy),
        .temp_source_o   (temp_source),
        .temp_value_o    (temp_value),
        .update_opt_o    (update_opt),
        .update_stage_o  (update_stage),
        .source_first_o  (source_first),
        .source_last_o   (source_last),
        .deep_sleep_o    (deep_sleep),
        .int_clk_en_o    (int_clk_en),
        .analog_en_o     (analog_en),
        .display_drive_o (display_drive)
    );

    host_model host (
        .sys_clk_i   (sys_clk_i),
        .busy_i      (busy),
        .host_byte_o (host_byte)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // reporting
    task automatic check(input logic [63:0] got, input logic [63:0] exp);
        cmp_count++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch at %0t: seen %h expected %h", $time, got, exp);
        end
    endtask

    task automatic complete_run();
        mismatches += host.stalls;
        $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    // command with up to two parameters, then a few idle cycles to settle
    task automatic cmd(input logic [7:0] code, a, b, input int n);
        host.send(1'b0, code, 1'b1);
        if (n > 0) host.send(1'b1, a, 1'b0);
        if (n > 1) host.send(1'b1, b, 1'b0);
        host.release_bus();
        repeat (3) @(posedge sys_clk_i);
        @(negedge sys_clk_i);
    endtask

    // bounded wait for a busy level, collecting which enables were seen high
    task automatic wait_busy(input logic level, input int limit);
        int n;
        n = 0;
        do begin
            @(negedge sys_clk_i);
            seen |= {int_clk_en, analog_en, display_drive};
            n++;
        end while (busy !== level && n < limit);
        if (busy !== level) begin
            mismatches++;
            complete_run();
        end
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        mismatches = 0;
        cmp_count  = 0;
        rst_b_i    = 1'b0;
        repeat (8) @(posedge sys_clk_i);
        rst_b_i <= 1'b1;
        @(negedge sys_clk_i);
        check(state_w, {8'h48, 12'h7ff, 9'h000, 8'hff, 8'h00, 8'haf});
        check({busy, deep_sleep, int_clk_en, analog_en}, 5'h00);
        // settings table
        foreach (rows[i]) begin
            cmd(rows[i].cmd, rows[i].a, rows[i].b, rows[i].n);
            check(state_w, rows[i].exp);
        end
        // each stage selection followed by activation
        foreach (stages[i]) begin
            cmd(epd_pkg::CMD_STAGE_SEL, stages[i].sel, 8'h00, 1);
            host.send(1'b0, epd_pkg::CMD_ACTIVATE, 1'b1);
            host.release_bus();
            seen = 3'b000;
            wait_busy(1'b1, 4);
            wait_busy(1'b0, 400);
            check(seen, stages[i].seen);
            check({int_clk_en, analog_en, display_drive}, {stages[i].last, 1'b0});
        end
        // restart with deep sleep set and a command byte plus its parameter thrown at it while busy
        cmd(epd_pkg::CMD_DEEP_SLEEP, 8'h01, 8'h00, 1);
        host.send(1'b0, epd_pkg::CMD_RESTART, 1'b1);
        host.release_bus();
        seen = 3'b000;
        wait_busy(1'b1, 4);
        repeat (2) @(posedge sys_clk_i);
        host.send(1'b0, epd_pkg::CMD_TEMP_SRC, 1'b0);
        host.send(1'b1, epd_pkg::TEMP_SRC_INTERNAL, 1'b0);
        host.release_bus();
        @(negedge sys_clk_i);
        check(busy, 1'b1);
        wait_busy(1'b0, 100);
        check(state_w, {8'h48, 12'h7ff, 9'h000, 8'hff, 8'h00, 8'haf});
        check({deep_sleep, int_clk_en, analog_en}, 4'h4);
        complete_run();
    end
endmodule
